// file: core/adc_control_registers.sv
// Function
// - result stored high eight, low two bits
// - result bits five to zero read zero
// - input n writes result register n
// - lower byte read from holding register
// - results cleared on reset and standby
// - control status cleared reset and standby
// - end flag set at conversion/group end
// - end flag cleared after read-one, write-zero
// - writing one to end flag ignored
// - interrupt enable gates end interrupt
// - start bit runs, single clears it
// - scan cycles until start bit cleared
// - bit four selects single or scan
// - bit three selects 266 or 134 states, 256 or 128 for scan conversions after the first
// - channel bits select input or group
// - external trigger stays disabled, reset zero
// - trigger bits six to zero read one
// - trigger control reinitialised to 7F
// - upper byte read captures lower byte
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers #(
    parameter logic [8:0] SLOW_STATES = adc_ctrl_pkg::CONV_STATES_SLOW,
    parameter logic [8:0] FAST_STATES = adc_ctrl_pkg::CONV_STATES_FAST
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic standby,
    input wire adc_ctrl_pkg::cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    input wire logic [9:0] sample_data,
    output logic [1:0] sample_channel,
    output logic conversion_end_interrupt
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][9:0] result;
        logic [7:0] ctrl;
        logic ext_trig;
        logic [7:0] hold;
        logic flag_seen;
        logic [7:0] rdata;
    } regs_t;

    regs_t r_q, r_d;
    adc_ctrl_pkg::conv_result_t conv;
    logic group_done;
    logic hit_wr;
    logic [1:0] rd_sel;

    function automatic logic [7:0] lower_byte(input logic [9:0] v);
        // bits 5..0 are reserved and always zero
        return {v[1:0], 6'h00};
    endfunction

    // result window decode, shared by the read path and the checks
    function automatic logic is_result_addr(input logic [15:0] a);
        return a >= adc_ctrl_pkg::ADDR_RESULT_A_UPPER &&
            a <= adc_ctrl_pkg::ADDR_RESULT_D_LOWER;
    endfunction

    adc_sequencer #(
        .SLOW_STATES(SLOW_STATES),
        .FAST_STATES(FAST_STATES)
    ) u_seq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(standby),
        .run(r_q.ctrl[adc_ctrl_pkg::BIT_START]),
        .scan(r_q.ctrl[adc_ctrl_pkg::BIT_SCAN]),
        .fast(r_q.ctrl[adc_ctrl_pkg::BIT_SPEED]),
        .sel(r_q.ctrl[1:0]),
        .sample_data(sample_data),
        .sample_channel(sample_channel),
        .result(conv),
        .group_done(group_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        rd_sel = cpu_req.addr[2:1];
        hit_wr = cpu_req.wr && (cpu_req.addr == adc_ctrl_pkg::ADDR_CONV_CTRL_STATUS);
        // result lands in register of converted input
        if (conv.done) begin
            r_d.result[conv.channel] = conv.value;
        end
        // read path, registered
        r_d.rdata = 8'h00;
        if (cpu_req.rd) begin
            if (is_result_addr(cpu_req.addr) && !cpu_req.addr[0]) begin
                r_d.rdata = r_q.result[rd_sel][9:2];
                r_d.hold = lower_byte(r_q.result[rd_sel]);
            end else if (is_result_addr(cpu_req.addr)) begin
                r_d.rdata = r_q.hold;
            end else if (cpu_req.addr == adc_ctrl_pkg::ADDR_CONV_CTRL_STATUS) begin
                r_d.rdata = r_q.ctrl;
                if (r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG]) begin
                    r_d.flag_seen = 1'b1;
                end
            end else if (cpu_req.addr == adc_ctrl_pkg::ADDR_TRIGGER_CONTROL) begin
                r_d.rdata = {r_q.ext_trig, 7'h00} | adc_ctrl_pkg::TRIGGER_RO_ONES;
            end
        end
        if (hit_wr) begin
            r_d.ctrl[6:0] = cpu_req.wdata[6:0];
            // only zero after a read of one clears
            if (!cpu_req.wdata[adc_ctrl_pkg::BIT_END_FLAG] && r_q.flag_seen) begin
                r_d.ctrl[adc_ctrl_pkg::BIT_END_FLAG] = 1'b0;
                r_d.flag_seen = 1'b0;
            end
        end
        // external trigger bit stored, never acted on
        if (cpu_req.wr && cpu_req.addr == adc_ctrl_pkg::ADDR_TRIGGER_CONTROL) begin
            r_d.ext_trig = cpu_req.wdata[adc_ctrl_pkg::BIT_EXT_TRIG];
        end
        // set wins over a clear in the same cycle
        if (group_done) begin
            r_d.ctrl[adc_ctrl_pkg::BIT_END_FLAG] = 1'b1;
            // single mode clears start bit on end
            if (!r_q.ctrl[adc_ctrl_pkg::BIT_SCAN] && !hit_wr) begin
                r_d.ctrl[adc_ctrl_pkg::BIT_START] = 1'b0;
            end
        end
        // scan keeps running while start bit stays set
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n || standby) begin
            r_q <= '0;
            r_q.ctrl <= adc_ctrl_pkg::RST_CTRL_STATUS;
            r_q.ext_trig <= adc_ctrl_pkg::RST_TRIGGER_CONTROL[adc_ctrl_pkg::BIT_EXT_TRIG];
        end else begin
            r_q <= r_d;
        end
    end

    assign cpu_rdata = r_q.rdata;
    // level interrupt from flag and enable
    assign conversion_end_interrupt = r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG] &
        r_q.ctrl[adc_ctrl_pkg::BIT_END_IE];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_group_end;
        group_done && !standby;
    endsequence

    sequence s_upper_read;
        cpu_req.rd && cpu_req.addr == adc_ctrl_pkg::ADDR_RESULT_A_UPPER && !standby;
    endsequence

    sequence s_lower_read;
        cpu_req.rd && cpu_req.addr == adc_ctrl_pkg::ADDR_RESULT_A_LOWER && !standby;
    endsequence

    // clearing write armed by a read of one, with no group end racing it
    sequence s_armed_clear;
        hit_wr && r_q.flag_seen && !cpu_req.wdata[adc_ctrl_pkg::BIT_END_FLAG] &&
        !group_done && !standby;
    endsequence

    flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_group_end |=> r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG])
        else $error("end flag not set after group end");

    irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (group_done && r_q.ctrl[adc_ctrl_pkg::BIT_END_IE] && !hit_wr && !standby)
        |=> conversion_end_interrupt)
        else $error("enabled group end raised no interrupt");

    no_blind_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hit_wr && !r_q.flag_seen && r_q.ctrl[7] && !standby) |=> r_q.ctrl[7])
        else $error("end flag cleared without prior read");

    one_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hit_wr && cpu_req.wdata[7] && !r_q.ctrl[7] && !group_done && !standby) |=> !r_q.ctrl[7])
        else $error("writing one set the end flag");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r_q.hold[5:0] == 6'h00)
        else $error("reserved result bits not zero");

    trig_ones_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.rd && cpu_req.addr == adc_ctrl_pkg::ADDR_TRIGGER_CONTROL && !standby)
        |=> cpu_rdata[6:0] == 7'h7F)
        else $error("trigger reserved bits not one");

    hold_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_upper_read ##1 (!cpu_req.rd && !standby) ##1 s_lower_read
        |=> cpu_rdata == lower_byte($past(r_q.result[0], 3)))
        else $error("lower byte not from captured value");

    single_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (group_done && !standby && !r_q.ctrl[adc_ctrl_pkg::BIT_SCAN] && !hit_wr)
        |=> !r_q.ctrl[adc_ctrl_pkg::BIT_START])
        else $error("start bit not cleared in single mode");

    standby_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        standby |=> (r_q.result == '0 && r_q.ctrl == 8'h00))
        else $error("standby did not clear registers");

    // ------------------------------------------------------------
    // read path checks
    // ------------------------------------------------------------
    upper_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.rd && is_result_addr(cpu_req.addr) && !cpu_req.addr[0] && !standby)
        |=> cpu_rdata == $past(r_q.result[cpu_req.addr[2:1]][9:2]))
        else $error("upper result byte not read directly");

    lower_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.rd && is_result_addr(cpu_req.addr) && cpu_req.addr[0] && !standby)
        |=> cpu_rdata == $past(r_q.hold))
        else $error("lower result byte not from holding register");

    // the holding register is shared, so every other access must leave it alone
    hold_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!(cpu_req.rd && is_result_addr(cpu_req.addr) && !cpu_req.addr[0]) && !standby)
        |=> r_q.hold == $past(r_q.hold))
        else $error("holding register changed without upper read");

    csr_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.rd && cpu_req.addr == adc_ctrl_pkg::ADDR_CONV_CTRL_STATUS && !standby)
        |=> cpu_rdata == $past(r_q.ctrl))
        else $error("control status read back wrong");

    // ------------------------------------------------------------
    // end flag checks
    // ------------------------------------------------------------
    flag_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.rd && !cpu_req.wr && cpu_req.addr == adc_ctrl_pkg::ADDR_CONV_CTRL_STATUS &&
        r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG] && !standby)
        |=> r_q.flag_seen)
        else $error("read of set flag did not arm clearing");

    armed_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_armed_clear |=> !r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG])
        else $error("armed clearing write left the flag set");

    flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG] && !standby &&
        !(hit_wr && r_q.flag_seen && !cpu_req.wdata[adc_ctrl_pkg::BIT_END_FLAG]))
        |=> r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG])
        else $error("end flag dropped without armed clear");

    // the group end is the only setter, a written one must not count
    flag_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG] && !group_done)
        |=> !r_q.ctrl[adc_ctrl_pkg::BIT_END_FLAG])
        else $error("end flag set without group end");

    irq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (conversion_end_interrupt && !hit_wr && !standby)
        |=> conversion_end_interrupt)
        else $error("interrupt dropped while flag and enable held");

    // ------------------------------------------------------------
    // control and result checks
    // ------------------------------------------------------------
    result_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (conv.done && !standby)
        |=> r_q.result[$past(conv.channel)] == $past(conv.value))
        else $error("result not stored in register of its input");

    start_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r_q.ctrl[adc_ctrl_pkg::BIT_START] && !group_done && !hit_wr && !standby)
        |=> r_q.ctrl[adc_ctrl_pkg::BIT_START])
        else $error("start bit dropped during conversion");

    scan_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r_q.ctrl[adc_ctrl_pkg::BIT_START] && r_q.ctrl[adc_ctrl_pkg::BIT_SCAN] && !hit_wr &&
        !standby)
        |=> r_q.ctrl[adc_ctrl_pkg::BIT_START])
        else $error("scan stopped without software clearing start");

    settings_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hit_wr && !standby)
        |=> r_q.ctrl[6:0] == $past(cpu_req.wdata[6:0]))
        else $error("control write not taken");

    trig_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cpu_req.wr && cpu_req.addr == adc_ctrl_pkg::ADDR_TRIGGER_CONTROL && !standby)
        |=> r_q.ext_trig == $past(cpu_req.wdata[adc_ctrl_pkg::BIT_EXT_TRIG]))
        else $error("trigger enable bit not stored");

    // no disable here, this one watches the reset itself
    reset_values_a: assert property (@(posedge ref_clk)
        (!rst_n || standby)
        |=> (r_q.result == '0 && r_q.ctrl == adc_ctrl_pkg::RST_CTRL_STATUS && !r_q.ext_trig))
        else $error("reset or standby left registers set");
endmodule
`default_nettype wire

// file: core/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
    // ------------------------------------------------------------
    // register addresses (lower 16 bits)
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RESULT_A_UPPER = 16'hFFE0;
    localparam logic [15:0] ADDR_RESULT_A_LOWER = 16'hFFE1;
    localparam logic [15:0] ADDR_RESULT_B_UPPER = 16'hFFE2;
    localparam logic [15:0] ADDR_RESULT_B_LOWER = 16'hFFE3;
    localparam logic [15:0] ADDR_RESULT_C_UPPER = 16'hFFE4;
    localparam logic [15:0] ADDR_RESULT_C_LOWER = 16'hFFE5;
    localparam logic [15:0] ADDR_RESULT_D_UPPER = 16'hFFE6;
    localparam logic [15:0] ADDR_RESULT_D_LOWER = 16'hFFE7;
    localparam logic [15:0] ADDR_CONV_CTRL_STATUS = 16'hFFE8;
    localparam logic [15:0] ADDR_TRIGGER_CONTROL = 16'hFFE9;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_END_FLAG = 7;
    localparam int BIT_END_IE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_SCAN = 4;
    localparam int BIT_SPEED = 3;
    localparam int BIT_GROUP_HIGH = 2;
    localparam int BIT_EXT_TRIG = 7;
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RST_TRIGGER_CONTROL = 8'h7F;
    localparam logic [7:0] TRIGGER_RO_ONES = 8'h7F;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    // ------------------------------------------------------------
    // timing in states (one state = one ref_clk cycle)
    // ------------------------------------------------------------
    localparam logic [8:0] CONV_STATES_SLOW = 9'h10A;
    localparam logic [8:0] CONV_STATES_FAST = 9'h086;
    localparam logic [8:0] CONV_STATES_SCAN_SLOW = 9'h100;
    localparam logic [8:0] CONV_STATES_SCAN_FAST = 9'h080;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic done;
        logic [1:0] channel;
        logic [9:0] value;
    } conv_result_t;
endpackage
`default_nettype wire

// file: core/adc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer #(
    parameter logic [8:0] SLOW_STATES = adc_ctrl_pkg::CONV_STATES_SLOW,
    parameter logic [8:0] FAST_STATES = adc_ctrl_pkg::CONV_STATES_FAST,
    parameter logic [8:0] SCAN_SLOW_STATES = adc_ctrl_pkg::CONV_STATES_SCAN_SLOW,
    parameter logic [8:0] SCAN_FAST_STATES = adc_ctrl_pkg::CONV_STATES_SCAN_FAST
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic run,
    input wire logic scan,
    input wire logic fast,
    input wire logic [1:0] sel,
    input wire logic [9:0] sample_data,
    output logic [1:0] sample_channel,
    output adc_ctrl_pkg::conv_result_t result,
    output logic group_done
);
    typedef struct packed {
        logic active;
        logic first;
        logic [8:0] count;
        logic [1:0] chan;
        adc_ctrl_pkg::conv_result_t res;
        logic gdone;
    } seq_state_t;

    seq_state_t s_q, s_d;
    logic [8:0] len;

    always_comb begin
        s_d = s_q;
        s_d.res.done = 1'b0;
        s_d.gdone = 1'b0;
        len = fast ? FAST_STATES : SLOW_STATES;
        if (scan && !s_q.first) begin
            len = fast ? SCAN_FAST_STATES : SCAN_SLOW_STATES;
        end
        if (!run) begin
            s_d.active = 1'b0;
        end else if (!s_q.active) begin
            // scan restarts from input 0, single starts at the selected input
            s_d.active = 1'b1;
            s_d.first = 1'b1;
            s_d.count = 9'h001;
            s_d.chan = scan ? 2'h0 : sel;
        end else if (s_q.count >= len) begin
            s_d.res.done = 1'b1;
            s_d.res.channel = s_q.chan;
            s_d.res.value = sample_data;
            s_d.count = 9'h001;
            s_d.first = 1'b0;
            if (!scan) begin
                s_d.gdone = 1'b1;
                s_d.active = 1'b0;
            end else if (s_q.chan == sel) begin
                s_d.gdone = 1'b1;
                s_d.chan = 2'h0;
            end else begin
                s_d.chan = s_q.chan + 2'h1;
            end
        end else begin
            s_d.count = s_q.count + 9'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || clear) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_channel = s_q.chan;
    assign result = s_q.res;
    assign group_done = s_q.gdone;
endmodule
`default_nettype wire

// file: sim/adc_control_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers_test;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [15:0] CSR = adc_ctrl_pkg::ADDR_CONV_CTRL_STATUS;
    localparam logic [15:0] TRG = adc_ctrl_pkg::ADDR_TRIGGER_CONTROL;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic standby = 1'b0;
    adc_ctrl_pkg::cpu_req_t cpu_req = '0;
    logic [7:0] cpu_rdata;
    logic [9:0] sample_data = 10'h000;
    logic [1:0] sample_channel;
    logic conversion_end_interrupt;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    int lim;
    logic [1:0] c;
    // reads carry the expected byte, writes the data written
    row_t rows [15] = '{{1'b0, 16'hFFE0, 8'h00}, {1'b0, 16'hFFE1, 8'h00},
        {1'b0, 16'hFFE2, 8'h00}, {1'b0, 16'hFFE3, 8'h00}, {1'b0, 16'hFFE4, 8'h00},
        {1'b0, 16'hFFE5, 8'h00}, {1'b0, 16'hFFE6, 8'h00}, {1'b0, 16'hFFE7, 8'h00},
        {1'b0, 16'hFFE8, 8'h00}, {1'b0, 16'hFFE9, 8'h7F}, {1'b0, 16'hFFEA, 8'h00},
        {1'b1, 16'hFFE9, 8'h00}, {1'b0, 16'hFFE9, 8'h7F}, {1'b1, 16'hFFE8, 8'h80},
        {1'b0, 16'hFFE8, 8'h00}};

    always #2.5 ref_clk = ~ref_clk;

    // converter value follows the channel, so a wrong mapping shows in the data
    always @(posedge ref_clk) begin
        sample_data <= {sample_channel, 8'h5A};
    end

    // short counts keep the run brief
    adc_control_registers #(.SLOW_STATES(9'h014), .FAST_STATES(9'h00A)) adc_control_registers_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .standby(standby),
        .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata),
        .sample_data(sample_data),
        .sample_channel(sample_channel),
        .conversion_end_interrupt(conversion_end_interrupt)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cpu_req.wr <= 1'b1;
        cpu_req.addr <= a;
        cpu_req.wdata <= d;
        @(posedge ref_clk);
        cpu_req.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        cpu_req.rd <= 1'b1;
        cpu_req.addr <= a;
        @(posedge ref_clk);
        cpu_req.rd <= 1'b0;
        #1;
        chk(cpu_rdata, exp, "read");
    endtask

    // bounded wait for the end interrupt
    task automatic wait_flag(output int cyc);
        cyc = 0;
        while (cyc < 1100) begin
            @(posedge ref_clk);
            #1;
            cyc++;
            if (conversion_end_interrupt === 1'b1) break;
        end
        chk({7'h00, conversion_end_interrupt}, 8'h01, "end interrupt");
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        #200000;
        mismatches++;
        $display("Error at %0t: timeout", $time);
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].data);
            else rchk(rows[i].addr, rows[i].data);
        end
        $display("register table test done");
        for (int ch = 0; ch < 4; ch++) begin
            c = ch[1:0];
            lim = c[0] ? 10 : 20;
            wr(CSR, {3'b011, 1'b0, c[0], 1'b0, c});
            wait_flag(n);
            chk({7'h00, n >= lim - 2 && n <= lim + 3}, 8'h01, "conversion time");
            chk({6'h00, sample_channel}, {6'h00, c}, "channel");
            repeat (2) @(posedge ref_clk);
            rchk(CSR, {3'b110, 1'b0, c[0], 1'b0, c});
            wr(CSR, {3'b010, 1'b0, c[0], 1'b0, c});
            rchk(CSR, {3'b010, 1'b0, c[0], 1'b0, c});
            chk({7'h00, conversion_end_interrupt}, 8'h00, "irq after clear");
            rchk(16'hFFE0 + {13'h0000, c, 1'b0}, {c, 6'h16});
            rchk(16'hFFE1 + {13'h0000, c, 1'b0}, 8'h80);
        end
        $display("single conversion test done");
        // flag with enable off, unarmed clear, write of one
        wr(CSR, 8'h20);
        repeat (40) @(posedge ref_clk);
        #1;
        chk({7'h00, conversion_end_interrupt}, 8'h00, "masked irq");
        wr(CSR, 8'h00);
        rchk(CSR, 8'h80);
        wr(CSR, 8'h80);
        rchk(CSR, 8'h80);
        wr(CSR, 8'h00);
        rchk(CSR, 8'h00);
        $display("flag test done");
        // scan over group 0-3, flag per group, runs until stopped
        wr(CSR, 8'h73);
        wait_flag(n);
        rchk(CSR, 8'hF3);
        wr(CSR, 8'h73);
        rchk(CSR, 8'h73);
        wait_flag(n);
        for (int ch = 0; ch < 4; ch++) begin
            c = ch[1:0];
            rchk(16'hFFE0 + {13'h0000, c, 1'b0}, {c, 6'h16});
        end
        rchk(CSR, 8'hF3);
        wr(CSR, 8'h53);
        rchk(CSR, 8'h53);
        repeat (900) @(posedge ref_clk);
        rchk(CSR, 8'h53);
        $display("scan test done");
        // standby and a reset in mid-run
        wr(CSR, 8'h73);
        repeat (100) @(posedge ref_clk);
        standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        standby <= 1'b0;
        rchk(16'hFFE0, 8'h00);
        rchk(CSR, 8'h00);
        rchk(TRG, 8'h7F);
        wr(CSR, 8'h73);
        repeat (100) @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(16'hFFE0, 8'h00);
        rchk(CSR, 8'h00);
        $display("standby and reset test done");
        test_done();
    end
endmodule
`default_nettype wire
